/* shared/gscr_pkg.sv */
// Purpose: constants and carrier types for the pin, scan and crossing register slice
// Assumes: eight channels, eight-bit register port, one 50 MHz clock
// Notes:   every register resets to zero; offsets are the register port addresses
package gscr_pkg;

  // channel count and widths
  localparam int unsigned GSCR_CHANS   = 8;
  localparam int unsigned GSCR_CHAN_W  = 4;
  localparam int unsigned GSCR_BLANK_W = 10;            // 127 x 8 fits in ten bits

  // register port addresses
  localparam logic [7:0] GSCR_ADDR_DRV_KIND  = 8'h09;   // output_driver_kind
  localparam logic [7:0] GSCR_ADDR_OUT_LVL   = 8'h0b;   // output_level_setting
  localparam logic [7:0] GSCR_ADDR_IN_LVL    = 8'h0d;   // input_level_readback
  localparam logic [7:0] GSCR_ADDR_BLANK     = 8'h0f;   // crossing_blank_setup
  localparam logic [7:0] GSCR_ADDR_SCAN_CTL  = 8'h10;   // scan_control
  localparam logic [7:0] GSCR_ADDR_IN_SEL    = 8'h11;   // input_selection

  // reset value shared by all registers
  localparam logic [7:0] GSCR_REG_RESET      = 8'h00;

  // field positions
  localparam int unsigned GSCR_BLANK_MULT_BIT = 7;
  localparam int unsigned GSCR_BLANK_CNT_MSB  = 6;
  localparam int unsigned GSCR_BLANK_SHIFT    = 3;      // times eight
  localparam int unsigned GSCR_SCAN_RUN_BIT   = 4;
  localparam int unsigned GSCR_SCAN_MODE_MSB  = 1;
  localparam int unsigned GSCR_HOST_CHAN_MSB  = 3;
  localparam int unsigned GSCR_XSRC_LSB       = 4;
  localparam logic [7:0]  GSCR_SCAN_WMASK     = 8'h13;  // writable bits of scan_control

  // start-of-scan search origin: above every channel
  localparam logic [3:0]  GSCR_SCAN_ORIGIN    = 4'hf;

  typedef enum logic [1:0] {
    GSCR_MODE_MANUAL = 2'b00,
    GSCR_MODE_AUTO   = 2'b01,
    GSCR_MODE_RSV2   = 2'b10,
    GSCR_MODE_RSV3   = 2'b11
  } gscr_mode_e;

  typedef enum logic {
    GSCR_SCAN_IDLE = 1'b0,
    GSCR_SCAN_RUN  = 1'b1
  } gscr_scan_e;

  // one finished conversion
  typedef struct packed {
    logic       done;
    logic [3:0] chan;
  } gscr_conv_s;

  // settings handed to the scan engine
  typedef struct packed {
    gscr_mode_e mode;
    logic       run;
    logic [3:0] host_chan;
    logic [3:0] xsrc;
    logic       mult;
    logic [6:0] blank;
    logic [7:0] members;
  } gscr_scan_cfg_s;

endpackage

/* verilog/gscr_scan_engine.sv */
// Purpose: channel sequencer and crossing-event blanking counter
// Assumes: conversion reports arrive as one-cycle pulses on the system clock
// Notes:   reserved scan modes behave as host-chosen selection
`timescale 1ns/100ps
module gscr_scan_engine
  import gscr_pkg::*;
(
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  input  wire gscr_scan_cfg_s       cfg,
  input  wire gscr_conv_s           conv,
  input  wire logic                 cross_raw,
  output logic [3:0]                next_chan,
  output logic                      scan_active,
  output logic                      cross_event,
  output logic [GSCR_BLANK_W-1:0]   blank_left
);

  // lowest enabled channel above cur, else lowest enabled, else cur itself, or channel 0 when cur is above 7
  function automatic logic [3:0] next_member(input logic [7:0] mask, input logic [3:0] cur);
    logic [3:0] pick;
    logic       found;
    pick  = (cur > 4'h7) ? 4'h0 : cur;
    found = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      if (mask[i] && (4'(i) > cur)) begin
        pick  = 4'(i);
        found = 1'b1;
      end
    end
    if (!found) begin
      for (int i = 7; i >= 0; i--) begin
        if (mask[i]) pick = 4'(i);
      end
    end
    return pick;
  endfunction

  // blanking reload value from the setup register
  function automatic logic [GSCR_BLANK_W-1:0] blank_load(input gscr_scan_cfg_s c);
    logic [GSCR_BLANK_W-1:0] base;
    base = GSCR_BLANK_W'(c.blank);
    return c.mult ? (base << GSCR_BLANK_SHIFT) : base;
  endfunction

  gscr_scan_e               state_r, state_nxt;
  logic [3:0]               chan_r, chan_nxt;
  logic [GSCR_BLANK_W-1:0]  cnt_r, cnt_nxt;
  logic                     event_r, event_nxt;
  logic                     auto_go;

  assign auto_go     = (cfg.mode == GSCR_MODE_AUTO) && cfg.run;
  assign next_chan   = chan_r;
  assign scan_active = (state_r == GSCR_SCAN_RUN);
  assign cross_event = event_r;
  assign blank_left  = cnt_r;

  // sequencer and blanking next state
  always_comb begin
    state_nxt = state_r;
    chan_nxt  = chan_r;
    cnt_nxt   = cnt_r;
    event_nxt = 1'b0;
    unique case (state_r)
      GSCR_SCAN_IDLE: begin
        if (auto_go) begin
          state_nxt = GSCR_SCAN_RUN;
          chan_nxt  = next_member(cfg.members, GSCR_SCAN_ORIGIN);
        end else if (cfg.mode != GSCR_MODE_AUTO) begin
          chan_nxt  = cfg.host_chan;
        end
      end
      GSCR_SCAN_RUN: begin
        if (!auto_go) begin
          state_nxt = GSCR_SCAN_IDLE;
          // leaving auto mode hands the mux straight back to the host, no stale scan channel
          if (cfg.mode != GSCR_MODE_AUTO) begin
            chan_nxt = cfg.host_chan;
          end
        end else if (conv.done) begin
          chan_nxt  = next_member(cfg.members, chan_r);
        end
      end
    endcase
    // a crossing counts only once the blanking budget is spent
    if (cross_raw && (cnt_r == '0)) begin
      event_nxt = 1'b1;
      cnt_nxt   = blank_load(cfg);
    end else if (conv.done && (conv.chan == cfg.xsrc) && (cnt_r != '0)) begin
      cnt_nxt   = cnt_r - 1'b1;
    end
  end

  // state registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= GSCR_SCAN_IDLE;
      chan_r  <= 4'h0;
      cnt_r   <= '0;
      event_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      chan_r  <= chan_nxt;
      cnt_r   <= cnt_nxt;
      event_r <= event_nxt;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  blank_hold_a: assert property (cnt_r != '0 |=> !event_r)
    else $error("crossing event raised while blanking");
  blank_load_a: assert property (event_r |-> cnt_r == blank_load($past(cfg)))
    else $error("blanking count not loaded from setup");
  manual_chan_a: assert property (cfg.mode == GSCR_MODE_MANUAL ##1 cfg.mode == GSCR_MODE_MANUAL |->
                                  chan_r == $past(cfg.host_chan))
    else $error("manual mode does not follow host channel");
  scan_step_a: assert property (scan_active && auto_go && conv.done && cfg.members != 8'h00
                                |=> cfg.members[chan_r[2:0]] || $changed(cfg.members))
    else $error("scan moved to a channel outside the member mask");
  scan_stop_a: assert property (scan_active && !auto_go |=> !scan_active)
    else $error("scan did not stop");

  scan_wrap_c:  cover property (scan_active && conv.done ##1 chan_r < $past(chan_r));
  blank_done_c: cover property (event_r ##[1:300] cnt_r == '0 ##[1:300] event_r);

endmodule // gscr_scan_engine

/* verilog/gscr_regs_top.sv */
// Purpose: register slice for pin drivers, pin readback, crossing blanking and scan control
// Assumes: register port inputs and pins are synchronous to CLK
// Notes:   read data appear one cycle after the read strobe
`timescale 1ns/100ps

// Overview of operation
// - driver-type bit: 0 open-drain, 1 push-pull
// - output-level bit sets the pin level
// - input readback is read-only sampled pin levels
// - multiplier bit scales blanking field by eight
// - ignore blanking-count source conversions after crossing
// - scan selection: host channel, sequencer, reserved
// - scan-run bit starts and stops ascending scan
// - scan-control reserved bits ignore writes, read zero
// - all registers reset to zero
// - channel-select low nibble host, high crossing source
// - pin-function bit: 0 analog, 1 digital
// - direction bit: 0 input, 1 output
module gscr_regs_top
  import gscr_pkg::*;
#(
  parameter int unsigned CHANS = GSCR_CHANS
)(
  input  wire logic                     CLK,
  input  wire logic                     RST_N,
  input  wire logic [7:0]               REG_ADDR,
  input  wire logic [7:0]               REG_WDATA,
  input  wire logic                     REG_WR,
  input  wire logic                     REG_RD,
  output logic [7:0]                    REG_RDATA,
  input  wire logic [CHANS-1:0]         PIN_FUNC,
  input  wire logic [CHANS-1:0]         PIN_DIR,
  input  wire logic [7:0]               SCAN_MEMBER_MASK,
  input  wire logic [CHANS-1:0]         GPIO_IN,
  output logic [CHANS-1:0]              GPIO_OUT,
  output logic [CHANS-1:0]              GPIO_OE,
  input  wire gscr_pkg::gscr_conv_s     CONV,
  input  wire logic                     CROSS_RAW,
  output logic [3:0]                    NEXT_CHAN,
  output logic [3:0]                    CROSS_SRC,
  output logic                          SCAN_ACTIVE,
  output logic                          CROSS_EVENT
);

  import gscr_pkg::*;

  logic [1:0]         rst_sync_r;
  logic               rst_n_int;
  logic [CHANS-1:0]   drv_kind_r, drv_kind_nxt;
  logic [CHANS-1:0]   out_lvl_r,  out_lvl_nxt;
  logic [CHANS-1:0]   in_lvl_r,   in_lvl_nxt;
  logic [7:0]         blank_r,    blank_nxt;
  logic [7:0]         scan_r,     scan_nxt;
  logic [7:0]         in_sel_r,   in_sel_nxt;
  logic [7:0]         rdata_r,    rdata_nxt;
  logic [CHANS-1:0]   pin_out_r,  pin_out_nxt;
  logic [CHANS-1:0]   pin_oe_r,   pin_oe_nxt;
  gscr_scan_cfg_s     scan_cfg;

  // reset release through two flops so every flop leaves reset on the same edge
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      rst_sync_r <= 2'b00;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_n_int = rst_sync_r[1];

  // register writes, pin sampling and read mux
  always_comb begin
    drv_kind_nxt = drv_kind_r;
    out_lvl_nxt  = out_lvl_r;
    blank_nxt    = blank_r;
    scan_nxt     = scan_r;
    in_sel_nxt   = in_sel_r;
    in_lvl_nxt   = GPIO_IN;
    rdata_nxt    = rdata_r;
    if (REG_WR) begin
      unique case (REG_ADDR)
        GSCR_ADDR_DRV_KIND: drv_kind_nxt = REG_WDATA[CHANS-1:0];
        GSCR_ADDR_OUT_LVL:  out_lvl_nxt  = REG_WDATA[CHANS-1:0];
        GSCR_ADDR_BLANK:    blank_nxt    = REG_WDATA;
        GSCR_ADDR_SCAN_CTL: scan_nxt     = REG_WDATA & GSCR_SCAN_WMASK;
        GSCR_ADDR_IN_SEL:   in_sel_nxt   = REG_WDATA;
        default:            ;                            // readback is not writable
      endcase
    end
    if (REG_RD) begin
      unique case (REG_ADDR)
        GSCR_ADDR_DRV_KIND: rdata_nxt = 8'(drv_kind_r);
        GSCR_ADDR_OUT_LVL:  rdata_nxt = 8'(out_lvl_r);
        GSCR_ADDR_IN_LVL:   rdata_nxt = 8'(in_lvl_r);
        GSCR_ADDR_BLANK:    rdata_nxt = blank_r;
        GSCR_ADDR_SCAN_CTL: rdata_nxt = scan_r & GSCR_SCAN_WMASK;
        GSCR_ADDR_IN_SEL:   rdata_nxt = in_sel_r;
        default:            rdata_nxt = GSCR_REG_RESET;  // unmapped reads zero
      endcase
    end
  end

  // pin drivers: analog pins and digital inputs are never driven
  always_comb begin
    for (int i = 0; i < CHANS; i++) begin
      if (PIN_FUNC[i] && PIN_DIR[i]) begin
        if (drv_kind_r[i]) begin
          pin_out_nxt[i] = out_lvl_r[i];
          pin_oe_nxt[i]  = 1'b1;
        end else begin
          pin_out_nxt[i] = 1'b0;
          pin_oe_nxt[i]  = !out_lvl_r[i];
        end
      end else begin
        pin_out_nxt[i] = 1'b0;
        pin_oe_nxt[i]  = 1'b0;
      end
    end
  end

  // register bank; every register starts at zero
  always_ff @(posedge CLK or negedge rst_n_int) begin
    if (!rst_n_int) begin
      drv_kind_r <= '0;
      out_lvl_r  <= '0;
      in_lvl_r   <= '0;
      blank_r    <= GSCR_REG_RESET;
      scan_r     <= GSCR_REG_RESET;
      in_sel_r   <= GSCR_REG_RESET;
      rdata_r    <= 8'h00;
      pin_out_r  <= '0;
      pin_oe_r   <= '0;
    end else begin
      drv_kind_r <= drv_kind_nxt;
      out_lvl_r  <= out_lvl_nxt;
      in_lvl_r   <= in_lvl_nxt;
      blank_r    <= blank_nxt;
      scan_r     <= scan_nxt;
      in_sel_r   <= in_sel_nxt;
      rdata_r    <= rdata_nxt;
      pin_out_r  <= pin_out_nxt;
      pin_oe_r   <= pin_oe_nxt;
    end
  end

  // settings for the scan engine
  assign scan_cfg.mode      = gscr_mode_e'(scan_r[GSCR_SCAN_MODE_MSB:0]);
  assign scan_cfg.run       = scan_r[GSCR_SCAN_RUN_BIT];
  assign scan_cfg.host_chan = in_sel_r[GSCR_HOST_CHAN_MSB:0];
  assign scan_cfg.xsrc      = in_sel_r[7:GSCR_XSRC_LSB];
  assign scan_cfg.mult      = blank_r[GSCR_BLANK_MULT_BIT];
  assign scan_cfg.blank     = blank_r[GSCR_BLANK_CNT_MSB:0];
  assign scan_cfg.members   = SCAN_MEMBER_MASK;

  gscr_scan_engine u_engine (
    .clk         (CLK),
    .rst_n       (rst_n_int),
    .cfg         (scan_cfg),
    .conv        (CONV),
    .cross_raw   (CROSS_RAW),
    .next_chan   (NEXT_CHAN),
    .scan_active (SCAN_ACTIVE),
    .cross_event (CROSS_EVENT),
    .blank_left  ()
  );

  assign REG_RDATA = rdata_r;
  assign GPIO_OUT  = pin_out_r;
  assign GPIO_OE   = pin_oe_r;
  assign CROSS_SRC = in_sel_r[7:GSCR_XSRC_LSB];

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!rst_n_int);

  push_pull_a: assert property (PIN_FUNC[0] && PIN_DIR[0] && drv_kind_r[0] |=>
                                GPIO_OE[0] && GPIO_OUT[0] == $past(out_lvl_r[0]))
    else $error("push-pull pin not driven to its level");
  level_write_a: assert property (REG_WR && REG_ADDR == GSCR_ADDR_OUT_LVL |=>
                                  out_lvl_r == $past(REG_WDATA[CHANS-1:0]))
    else $error("output level write lost");
  readback_a: assert property (REG_RD && REG_ADDR == GSCR_ADDR_IN_LVL ##1 1'b1 |->
                               REG_RDATA == 8'($past(GPIO_IN, 2)))
    else $error("readback does not show pin levels");
  scan_resv_a: assert property (REG_RD && REG_ADDR == GSCR_ADDR_SCAN_CTL |=>
                                REG_RDATA[7:5] == 3'h0 && REG_RDATA[3:2] == 2'h0)
    else $error("reserved scan bits read nonzero");
  reset_zero_a: assert property ($rose(rst_n_int) |-> drv_kind_r == '0 && out_lvl_r == '0 &&
                                 blank_r == 8'h00 && scan_r == 8'h00 && in_sel_r == 8'h00)
    else $error("register not zero after reset");
  chan_sel_a: assert property (REG_WR && REG_ADDR == GSCR_ADDR_IN_SEL |=>
                               CROSS_SRC == $past(REG_WDATA[7:4]))
    else $error("crossing source not taken from write");
  not_output_a: assert property (!(PIN_FUNC[1] && PIN_DIR[1]) |=> !GPIO_OE[1])
    else $error("non-output pin driven");
  open_drain_a: assert property (PIN_FUNC[2] && PIN_DIR[2] && !drv_kind_r[2] |=>
                                 !GPIO_OUT[2] && GPIO_OE[2] == !$past(out_lvl_r[2]))
    else $error("open-drain pin drives high");
  // the sample flop is checked only once it has left reset, so a pin high at release is no error
  sample_flop_a: assert property ($past(rst_n_int) |-> in_lvl_r == $past(GPIO_IN))
    else $error("pin sample flop does not follow pins");
  resv_store_a: assert property (REG_WR && REG_ADDR == GSCR_ADDR_SCAN_CTL |=>
                                 scan_r[7:5] == 3'h0 && scan_r[3:2] == 2'h0)
    else $error("reserved scan bits stored");
  mode_field_a: assert property (REG_WR && REG_ADDR == GSCR_ADDR_SCAN_CTL |=>
                                 scan_cfg.mode == gscr_mode_e'($past(REG_WDATA[1:0])))
    else $error("scan mode not taken from write");
  kind_write_a: assert property (REG_WR && REG_ADDR == GSCR_ADDR_DRV_KIND |=>
                                 drv_kind_r == $past(REG_WDATA[CHANS-1:0]))
    else $error("driver kind write lost");

  od_release_c: cover property (PIN_FUNC[0] && PIN_DIR[0] && !drv_kind_r[0] && out_lvl_r[0]);
  auto_run_c:   cover property (REG_WR && REG_ADDR == GSCR_ADDR_SCAN_CTL && REG_WDATA == 8'h11 ##[1:20] SCAN_ACTIVE);
  crossing_c:   cover property (CROSS_EVENT);

endmodule // gscr_regs_top

/* testbench/gscr_pin_world.sv */
// Purpose: board-side model of the eight channel pins
// Assumes: each pin has a pull-up; an external source drives only pins that are not outputs
// Notes:   the pull-up defines the level of a released open-drain pin
`timescale 1ns/100ps
module gscr_pin_world #(
  parameter int unsigned CHANS = 8
)(
  input  wire logic [CHANS-1:0] gpio_out,
  input  wire logic [CHANS-1:0] gpio_oe,
  input  wire logic [CHANS-1:0] ext_val,
  input  wire logic [CHANS-1:0] ext_en,
  output logic [CHANS-1:0]      pin_level
);
  // wire resolution: device driver first, then external source, else pull-up
  always_comb begin
    for (int i = 0; i < CHANS; i++) begin
      if (gpio_oe[i])
        pin_level[i] = gpio_out[i];
      else if (ext_en[i])
        pin_level[i] = ext_val[i];
      else
        pin_level[i] = 1'b1;
    end
  end
endmodule // gscr_pin_world

/* testbench/tb.sv */
// Purpose: self-checking bench for the pin, scan and crossing register slice
// Assumes: inputs change at the falling edge; reads land two edges after the strobe
// Notes:   random values come from a fixed seed so every run repeats
`timescale 1ns/100ps
module tb;
  import gscr_pkg::*;
  logic       clk, rst_n, reg_wr, reg_rd, scan_active, cross_event, seen;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, pin_func, pin_dir, mask;
  logic [7:0] gpio_in, gpio_out, gpio_oe, ext_val, kind, lvl, v, outp;
  logic [3:0] next_chan, cross_src, ch;
  gscr_conv_s conv;
  logic       cross_raw;
  int         fails, checked, n;
  logic [7:0] addrs [6] = '{8'h09, 8'h0b, 8'h0d, 8'h0f, 8'h10, 8'h11};
  logic [7:0] blanks [4];

  gscr_regs_top gscr_regs_top_inst (.CLK(clk), .RST_N(rst_n), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
    .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .PIN_FUNC(pin_func), .PIN_DIR(pin_dir),
    .SCAN_MEMBER_MASK(mask), .GPIO_IN(gpio_in), .GPIO_OUT(gpio_out), .GPIO_OE(gpio_oe), .CONV(conv),
    .CROSS_RAW(cross_raw), .NEXT_CHAN(next_chan), .CROSS_SRC(cross_src), .SCAN_ACTIVE(scan_active),
    .CROSS_EVENT(cross_event));
  // external source only on pins that are not outputs, so no contention
  gscr_pin_world gscr_pin_world_inst (.gpio_out(gpio_out), .gpio_oe(gpio_oe), .ext_val(ext_val),
    .ext_en(~(pin_func & pin_dir)), .pin_level(gpio_in));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // expected blanking length from the setup byte
  function automatic int blank_cnt(input logic [7:0] b);
    return b[7] ? int'(b[6:0]) * 8 : int'(b[6:0]);
  endfunction

  // next enabled channel above cur, wrapping to the lowest
  function automatic logic [3:0] next_mem(input logic [7:0] m, input logic [3:0] cur);
    for (int i = 1; i <= 8; i++) begin
      if (m[(int'(cur) + i) % 8])
        return 4'((int'(cur) + i) % 8);
    end
    return 4'h0;
  endfunction

  task automatic final_report;
    if (fails == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tick(input int k);
    repeat (k) @(negedge clk);
  endtask

  // one write strobe, then an idle cycle so the register has landed
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    tick(1);
    reg_wr = 1'b0;
    tick(1);
  endtask

  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    reg_addr = a;
    reg_rd = 1'b1;
    tick(1);
    reg_rd = 1'b0;
    tick(1);
    chk(reg_rdata, exp);
  endtask

  task automatic conv_pulse(input logic [3:0] c);
    conv = '{done: 1'b1, chan: c};
    tick(1);
    conv = '0;
    tick(1);
  endtask

  // an accepted event is a single pulse one edge after the raw crossing
  task automatic raw_pulse(input logic exp);
    cross_raw = 1'b1;
    tick(1);
    cross_raw = 1'b0;
    seen = cross_event;
    tick(1);
    chk({seen, cross_event}, {exp, 1'b0});
  endtask

  initial begin
    rst_n = 1'b0; reg_addr = '0; reg_wdata = '0; reg_wr = 1'b0; reg_rd = 1'b0; pin_func = '0;
    pin_dir = '0; mask = '0; ext_val = '0; conv = '0; cross_raw = 1'b0; fails = 0; checked = 0;
    n = $urandom(40625);
    repeat (2) @(posedge clk);
    @(negedge clk) rst_n = 1'b1;
    tick(4);
    // reset state, with one unmapped address
    foreach (addrs[i]) rchk(addrs[i], 8'h00);
    rchk(8'h0a, 8'h00);
    chk({gpio_oe, next_chan, 3'b0, scan_active}, 16'h0000);
    // plain read/write registers with random data
    for (int i = 0; i < 24; i++) begin
      v = 8'($urandom);
      wr(addrs[(i % 4 == 2) ? 5 : ((i % 4 == 3) ? 3 : i % 4)], v);
      rchk(addrs[(i % 4 == 2) ? 5 : ((i % 4 == 3) ? 3 : i % 4)], v);
    end
    wr(8'h10, 8'hff);
    rchk(8'h10, 8'h13);
    wr(8'h0d, 8'hff);
    rchk(8'h0d, 8'h00);
    // pin drivers against function, direction, kind and level
    repeat (20) begin
      pin_func = 8'($urandom); pin_dir = 8'($urandom); ext_val = 8'($urandom);
      kind = 8'($urandom); lvl = 8'($urandom);
      wr(8'h09, kind);
      wr(8'h0b, lvl);
      tick(2);
      outp = pin_func & pin_dir;
      chk(gpio_oe, outp & (kind | ~lvl));
      chk(gpio_out, outp & kind & lvl);
      rchk(8'h0d, (outp & lvl) | (~outp & ext_val));
    end
    // host selection in manual and reserved modes, run bit set
    foreach (addrs[m]) if (m < 4 && m != 1) begin
      wr(8'h10, 8'(m) | 8'h10);
      v = 8'($urandom) & 8'h77;
      wr(8'h11, v);
      tick(1);
      chk({next_chan, cross_src, 7'b0, scan_active}, {v[3:0], v[7:4], 8'h00});
    end
    // automatic scan, random members and a single top member
    for (int k = 0; k < 2; k++) begin
      mask = k ? 8'h80 : (8'($urandom) | 8'h01);
      wr(8'h10, 8'h11);
      tick(1);
      ch = next_mem(mask, 4'h7);
      chk({next_chan, 7'b0, scan_active}, {ch, 8'h01});
      repeat (10) begin
        conv_pulse(ch);
        ch = next_mem(mask, ch);
        chk(next_chan, ch);
      end
      wr(8'h10, 8'h01);
      tick(1);
      chk(scan_active, 1'b0);
    end
    // crossing blanking: other channels must not count
    wr(8'h11, 8'h30);
    blanks = '{8'h03, 8'h82, 8'h00, 8'($urandom) & 8'h87};
    foreach (blanks[b]) begin
      wr(8'h0f, blanks[b]);
      n = blank_cnt(blanks[b]);
      raw_pulse(1'b1);
      repeat (n) begin
        raw_pulse(1'b0);
        conv_pulse(4'h5);
        conv_pulse(4'h3);
      end
      raw_pulse(1'b1);
      repeat (n) conv_pulse(4'h3);
    end
    final_report();
  end
endmodule // tb
